// *** shared/osc_sleep_params.svh ***
// register offsets, field positions, masks and timing counts
`ifndef OSC_SLEEP_PARAMS_SVH
`define OSC_SLEEP_PARAMS_SVH
`define FAST_TRIM_OFFSET      8'h63
`define TEMP_COEF_OFFSET      8'h64
`define TEMP_STEP_OFFSET      8'h65
`define SLOW_TRIM_OFFSET      8'h66
`define CORE_CTRL_OFFSET      8'h67
`define SLEEP_STATUS_OFFSET   8'h68
`define COEF_SIGN_BIT         7
`define STEP_ENABLE_BIT       7
`define SLEEP_ARM_BIT         4
`define SLEEP_SEL_LSB         5
`define SLOW_TRIM_MASK        8'h03
`define CORE_CTRL_MASK        8'h70
`define WAKE_STALL_CYCLES     4
`define STANDBY_WAKE_CYCLES   6
`define OSC_STARTUP_CYCLES    6
`endif

// *** shared/osc_sleep_pkg.sv ***
// types shared by the trim and sleep controller
package osc_sleep_pkg;
    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_NOISE_REDUCTION,
        MODE_POWER_DOWN,
        MODE_STANDBY
    } sleep_mode_t;

    typedef struct packed {
        logic core;
        logic program_memory;
        logic peripheral_io;
        logic converter;
        logic main_osc;
    } clock_enables_t;

    // wake event inputs, one bit each
    typedef struct packed {
        logic any_interrupt;
        logic watchdog;
        logic ext_external_interrupt_zero_level;
        logic ext_external_interrupt_zero_edge;
        logic pin_change;
        logic converter_done;
        logic memory_ready;
        logic serial_start;
        logic receiver_start_frame;
        logic two_wire_match;
    } wake_events_t;

    typedef struct packed {
        logic [7:0] address;
        logic [7:0] write_data;
        logic       write_strobe;
        logic       read_strobe;
    } reg_request_t;
endpackage : osc_sleep_pkg

// *** verilog/factory_cal_store.sv ***
`timescale 1ns/1ps
// factory calibration store with registered read port
module factory_cal_store #(
    parameter int         WORDS = 4,
    parameter logic [7:0] FAST_CAL = 8'h80,
    parameter logic [7:0] COEF_CAL = 8'h00,
    parameter logic [7:0] STEP_CAL = 8'h00,
    parameter logic [7:0] SLOW_CAL = 8'h02
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] read_index,
    output logic      [7:0] read_data
);
    logic [7:0] table_mem [WORDS];
    logic [7:0] read_data_reg;

    // values are fixed at build time, standing in for a fuse row
    assign table_mem[0] = FAST_CAL;
    assign table_mem[1] = COEF_CAL;
    assign table_mem[2] = STEP_CAL;
    assign table_mem[3] = SLOW_CAL;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_data_reg <= 8'h00;
        end else begin
            read_data_reg <= table_mem[read_index];
        end
    end
    assign read_data = read_data_reg;
endmodule : factory_cal_store

// *** verilog/osc_trim_and_sleep_control.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "osc_sleep_params.svh"
// What this block does
// [RULE_01] reset reloads every trim from factory values
// [RULE_02] fast trim eight bits, zero slowest
// [RULE_03] software keeps fast trim low during writes
// [RULE_04] software steps fast trim at most 0x20
// [RULE_05] coefficient: bit 7 sign, 6:0 magnitude
// [RULE_06] step bit 7 enables temperature compensation
// [RULE_07] step bits 6:0: 0x00 largest step
// [RULE_08] software retrims fast value on enable change
// [RULE_09] slow trim bits 7:2 read zero
// [RULE_10] sleep only on instruction with arm set
// [RULE_11] interrupt wake stalls four extra cycles
// [RULE_12] sleep leaves register file and memory
// [RULE_13] reset during sleep restarts from vector
// [RULE_14] idle stops core and program memory clocks
// [RULE_15] noise reduction also stops io clock
// [RULE_16] converter enabled starts conversion on idle or noise reduction entry
// [RULE_17] power-down stops oscillator and all clocks
// [RULE_18] power-down wakes only on listed events
// [RULE_19] deeper modes wake on external_interrupt_zero level only
// [RULE_20] standby like power-down, six cycle wake
// [RULE_21] level wake source holds its level
// [RULE_22] select: idle, noise, power-down, standby
// [RULE_23] software arms just before sleeping
// [RULE_24] clock gates switch only while low
module osc_trim_and_sleep_control #(
    parameter logic [7:0] FAST_CAL = 8'h80,
    parameter logic [7:0] COEF_CAL = 8'h00,
    parameter logic [7:0] STEP_CAL = 8'h00,
    parameter logic [7:0] SLOW_CAL = 8'h02
) (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire osc_sleep_pkg::reg_request_t reg_req,
    output logic                       [7:0] read_data,
    input  wire logic                        sleep_instruction,
    input  wire logic                        converter_enabled,
    input  wire osc_sleep_pkg::wake_events_t wake_pins,
    output logic                       [7:0] fast_trim_value,
    output logic                       [7:0] slow_trim_value,
    output logic                       [7:0] temp_coefficient_out,
    output logic                       [6:0] temp_step_out,
    output logic                             temp_comp_enable,
    output osc_sleep_pkg::clock_enables_t    clock_enables,
    output logic                             core_stall,
    output logic                             interrupt_go,
    output logic                             conversion_start,
    output logic                             sleeping
);
    import osc_sleep_pkg::*;

    typedef enum logic [2:0] {
        ST_LOAD,
        ST_RUN,
        ST_ENTER,
        ST_SLEEP,
        ST_STARTUP,
        ST_STALL
    } phase_t;

    typedef struct packed {
        phase_t         phase;
        logic [1:0]     load_index;
        logic [7:0]     fast_trim;
        logic [7:0]     temp_coef;
        logic [7:0]     temp_step;
        logic [1:0]     slow_trim;
        logic           sleep_arm;
        sleep_mode_t    sleep_select;
        sleep_mode_t    active_mode;
        logic [3:0]     count;
        logic           irq_wake;
        logic [7:0]     read_data;
        clock_enables_t gates;
        logic           stall;
        logic           irq_go;
        logic           conv_start;
        wake_events_t   sync1;
        wake_events_t   sync2;
        logic [7:0]     coef_out;
        logic [6:0]     step_out;
        logic           asleep;
    } state_t;

    localparam logic [3:0] STALL_N = 4'(`WAKE_STALL_CYCLES);
    localparam logic [3:0] STARTUP_N = 4'(`OSC_STARTUP_CYCLES);
    localparam logic [3:0] STANDBY_N = 4'(`STANDBY_WAKE_CYCLES);
    localparam clock_enables_t ALL_ON = '1;

    state_t     st_reg;
    state_t     st_next;
    logic [7:0] cal_word;
    logic       wake_ok;

    // factory values are read out one per cycle after reset
    factory_cal_store #(
        .FAST_CAL (FAST_CAL),
        .COEF_CAL (COEF_CAL),
        .STEP_CAL (STEP_CAL),
        .SLOW_CAL (SLOW_CAL)
    ) cal_store (
        .clk        (clk),
        .reset_n    (reset_n),
        .read_index (st_reg.load_index),
        .read_data  (cal_word)
    );

    // wake qualification per mode, on synchronised inputs
    always_comb begin
        wake_ok = 1'b0;
        unique case (st_reg.active_mode)
            MODE_IDLE: begin
                wake_ok = st_reg.sync2.any_interrupt; // RULE_14
            end
            MODE_NOISE_REDUCTION: begin
                wake_ok = st_reg.sync2.watchdog // RULE_15
                    | st_reg.sync2.ext_external_interrupt_zero_level // RULE_19
                    | st_reg.sync2.pin_change
                    | st_reg.sync2.converter_done
                    | st_reg.sync2.memory_ready
                    | st_reg.sync2.serial_start
                    | st_reg.sync2.receiver_start_frame
                    | st_reg.sync2.two_wire_match;
            end
            MODE_POWER_DOWN, MODE_STANDBY: begin
                wake_ok = st_reg.sync2.watchdog // RULE_18
                    | st_reg.sync2.ext_external_interrupt_zero_level // RULE_19
                    | st_reg.sync2.pin_change
                    | st_reg.sync2.serial_start
                    | st_reg.sync2.receiver_start_frame
                    | st_reg.sync2.two_wire_match;
            end
        endcase
    end

    // glitch-free gating: enables change only on the falling edge
    clock_enables_t gate_low_reg;
    always_ff @(negedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_low_reg <= ALL_ON;
        end else begin
            gate_low_reg <= st_reg.gates; // RULE_24
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = wake_pins;
        st_next.sync2 = st_reg.sync1;
        st_next.irq_go = 1'b0;
        st_next.conv_start = 1'b0;
        st_next.read_data = 8'h00;

        // register reads: data stand in the next cycle only
        if (reg_req.read_strobe) begin
            unique case (reg_req.address)
                `FAST_TRIM_OFFSET: st_next.read_data = st_reg.fast_trim;
                `TEMP_COEF_OFFSET: st_next.read_data = st_reg.temp_coef;
                `TEMP_STEP_OFFSET: st_next.read_data = st_reg.temp_step;
                `SLOW_TRIM_OFFSET: begin
                    st_next.read_data = {6'h00, st_reg.slow_trim}; // RULE_09
                end
                `CORE_CTRL_OFFSET: begin
                    st_next.read_data = {1'b0, st_reg.sleep_select,
                        st_reg.sleep_arm, 4'h0};
                end
                `SLEEP_STATUS_OFFSET: begin
                    st_next.read_data = {5'h00, st_reg.phase};
                end
                default: st_next.read_data = 8'h00;
            endcase
        end

        if (reg_req.write_strobe && st_reg.phase != ST_LOAD) begin
            unique case (reg_req.address)
                `FAST_TRIM_OFFSET: begin
                    st_next.fast_trim = reg_req.write_data; // RULE_02
                end
                `TEMP_COEF_OFFSET: begin
                    st_next.temp_coef = reg_req.write_data; // RULE_05
                end
                `TEMP_STEP_OFFSET: begin
                    st_next.temp_step = reg_req.write_data; // RULE_07
                end
                `SLOW_TRIM_OFFSET: begin
                    st_next.slow_trim = reg_req.write_data[1:0]; // RULE_09
                end
                `CORE_CTRL_OFFSET: begin
                    st_next.sleep_arm =
                        reg_req.write_data[`SLEEP_ARM_BIT];
                    st_next.sleep_select = sleep_mode_t'(
                        reg_req.write_data[`SLEEP_SEL_LSB +: 2]); // RULE_22
                end
                default: begin
                end
            endcase
        end

        unique case (st_reg.phase)
            ST_LOAD: begin
                // store output lags its index by one cycle
                st_next.load_index = st_reg.load_index + 2'd1;
                st_next.count = st_reg.count + 4'd1;
                unique case (st_reg.count[2:0])
                    3'd1: st_next.fast_trim = cal_word; // RULE_01
                    3'd2: st_next.temp_coef = cal_word;
                    3'd3: st_next.temp_step = cal_word;
                    3'd4: begin
                        st_next.slow_trim = cal_word[1:0];
                        st_next.phase = ST_RUN;
                        st_next.count = 4'd0;
                    end
                    default: begin
                    end
                endcase
            end
            ST_RUN: begin
                if (sleep_instruction && st_reg.sleep_arm) begin // RULE_10
                    st_next.active_mode = st_reg.sleep_select;
                    st_next.stall = 1'b1;
                    st_next.phase = ST_ENTER;
                end
            end
            ST_ENTER: begin
                st_next.gates = ALL_ON;
                st_next.gates.core = 1'b0; // RULE_14
                st_next.gates.program_memory = 1'b0;
                unique case (st_reg.active_mode)
                    MODE_IDLE: begin
                        st_next.conv_start = converter_enabled; // RULE_16
                    end
                    MODE_NOISE_REDUCTION: begin
                        st_next.gates.peripheral_io = 1'b0; // RULE_15
                        st_next.conv_start = converter_enabled; // RULE_16
                    end
                    MODE_POWER_DOWN: begin
                        st_next.gates = '0; // RULE_17
                    end
                    MODE_STANDBY: begin
                        st_next.gates = '0; // RULE_20
                        st_next.gates.main_osc = 1'b1;
                    end
                endcase
                st_next.phase = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake_ok) begin
                    st_next.irq_wake = 1'b1;
                    st_next.gates.main_osc = 1'b1;
                    st_next.count = 4'd0;
                    st_next.phase = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                // standby already has a running oscillator
                st_next.count = st_reg.count + 4'd1;
                if ((st_reg.active_mode == MODE_STANDBY
                        && st_reg.count == STANDBY_N - 4'd1) // RULE_20
                    || (st_reg.active_mode != MODE_STANDBY
                        && st_reg.count == STARTUP_N - 4'd1)) begin
                    st_next.gates = ALL_ON;
                    st_next.count = 4'd0;
                    st_next.phase = ST_STALL;
                end
            end
            ST_STALL: begin
                st_next.count = st_reg.count + 4'd1;
                if (st_reg.count == STALL_N - 4'd1) begin // RULE_11
                    st_next.stall = 1'b0;
                    st_next.irq_go = st_reg.irq_wake;
                    st_next.irq_wake = 1'b0;
                    st_next.count = 4'd0;
                    st_next.phase = ST_RUN;
                end
            end
        endcase

        // compensation has no effect while disabled; taken from the
        // next state so the registered outputs never lag the registers
        st_next.coef_out = st_next.temp_step[`STEP_ENABLE_BIT]
            ? st_next.temp_coef : 8'h00; // RULE_06
        st_next.step_out = st_next.temp_step[`STEP_ENABLE_BIT]
            ? st_next.temp_step[6:0] : 7'h00; // RULE_06
        st_next.asleep = (st_next.phase == ST_SLEEP);
    end

    // reset restarts from vector; trims and memory are not touched
    // by sleep itself, only by reset and by register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '{phase: ST_LOAD, active_mode: MODE_IDLE,
                sleep_select: MODE_IDLE, gates: ALL_ON,
                stall: 1'b1, default: '0}; // RULE_13
        end else begin
            st_reg <= st_next; // RULE_12
        end
    end

    assign read_data = st_reg.read_data;
    assign fast_trim_value = st_reg.fast_trim;
    assign slow_trim_value = {6'h00, st_reg.slow_trim};
    assign temp_coefficient_out = st_reg.coef_out;
    assign temp_step_out = st_reg.step_out;
    assign temp_comp_enable = st_reg.temp_step[`STEP_ENABLE_BIT];
    assign clock_enables = gate_low_reg;
    assign core_stall = st_reg.stall;
    assign interrupt_go = st_reg.irq_go;
    assign conversion_start = st_reg.conv_start;
    assign sleeping = st_reg.asleep;

    logic [3:0] stall_len;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stall_len <= 4'd0;
        end else begin
            stall_len <= (st_reg.phase == ST_STALL) ? stall_len + 4'd1
                : 4'd0;
        end
    end

    default clocking assert_clk @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    stall_four_a: assert property ( // RULE_11
        st_reg.phase == ST_STALL |-> stall_len < STALL_N)
        else $error("wake stall too long");
    sleep_arm_a: assert property ( // RULE_10
        st_reg.phase == ST_RUN && !st_reg.sleep_arm
        |=> st_reg.phase != ST_ENTER)
        else $error("sleep entered while not armed");
    slow_zero_a: assert property ( // RULE_09
        $past(reg_req.read_strobe) && $past(reg_req.address) == 8'h66
        |-> read_data[7:2] == 6'h00)
        else $error("slow trim upper bits set");
    comp_off_a: assert property ( // RULE_06
        !st_reg.temp_step[7] |-> temp_step_out == 7'h00)
        else $error("compensation active while disabled");
    idle_gates_a: assert property ( // RULE_14
        st_reg.phase == ST_SLEEP && st_reg.active_mode == MODE_IDLE
        |-> !st_reg.gates.core && st_reg.gates.peripheral_io)
        else $error("idle gating wrong");
    pd_gates_a: assert property ( // RULE_17
        st_reg.phase == ST_SLEEP && st_reg.active_mode == MODE_POWER_DOWN
        |-> st_reg.gates == '0)
        else $error("power-down clocks running");
    edge_nowake_a: assert property ( // RULE_19
        st_reg.phase == ST_SLEEP && st_reg.active_mode != MODE_IDLE
        && st_reg.sync2 == wake_events_t'(10'h040)
        |=> st_reg.phase == ST_SLEEP)
        else $error("edge trigger woke deep sleep");
    standby_six_a: assert property ( // RULE_20
        st_reg.phase == ST_SLEEP && wake_ok
        && st_reg.active_mode == MODE_STANDBY
        |=> st_reg.phase == ST_STARTUP [*6] ##1 st_reg.phase == ST_STALL)
        else $error("standby wake not six cycles");
    load_a: assert property ( // RULE_01
        st_reg.phase == ST_RUN && $past(st_reg.phase) == ST_LOAD
        |-> fast_trim_value == FAST_CAL)
        else $error("factory trim not loaded");
endmodule : osc_trim_and_sleep_control

// *** bench/osc_trim_and_sleep_control_tb.sv ***
// self-checking bench for the trim registers and the sleep controller
`timescale 1ns/1ps
`include "osc_sleep_params.svh"
module osc_trim_and_sleep_control_tb;
    import osc_sleep_pkg::*;
    localparam logic [7:0] FAST_F = 8'h5a;
    localparam logic [7:0] COEF_F = 8'h93;
    localparam logic [7:0] STEP_F = 8'h85;
    localparam logic [7:0] SLOW_F = 8'h02;
    localparam logic [7:0] RD_MASK [5] = '{8'hff, 8'hff, 8'hff, 8'h03, 8'h70};
    // wake bits, msb first: any_int, wdog, external_interrupt_zero lvl, external_interrupt_zero edge, pin, adc,
    // mem ready, serial start, rx frame, two-wire
    localparam logic [9:0] ALLOW [4] = '{10'h200, 10'h1bf, 10'h1a7, 10'h1a7};
    localparam logic [9:0] FORBID [4] = '{10'h000, 10'h040, 10'h258, 10'h258};
    localparam logic [4:0] GATES [4] = '{5'h07, 5'h03, 5'h00, 5'h01};
    logic           clk;
    logic           reset_n;
    reg_request_t   reg_req;
    logic     [7:0] read_data;
    logic           sleep_instruction;
    logic           converter_enabled;
    wake_events_t   wake_pins;
    logic     [7:0] fast_trim_value;
    logic     [7:0] slow_trim_value;
    logic     [7:0] temp_coefficient_out;
    logic     [6:0] temp_step_out;
    logic           temp_comp_enable;
    clock_enables_t clock_enables;
    logic           core_stall;
    logic           interrupt_go;
    logic           conversion_start;
    logic           sleeping;
    logic     [7:0] m [5];
    int             error_cnt = 0;
    int             n_checks = 0;
    int             go_cnt = 0;
    int             conv_cnt = 0;
    int             cycles = 0;

    osc_trim_and_sleep_control #(.FAST_CAL(FAST_F), .COEF_CAL(COEF_F),
        .STEP_CAL(STEP_F), .SLOW_CAL(SLOW_F)) osc_trim_and_sleep_control_inst (
        .clk(clk), .reset_n(reset_n), .reg_req(reg_req),
        .read_data(read_data), .sleep_instruction(sleep_instruction),
        .converter_enabled(converter_enabled), .wake_pins(wake_pins),
        .fast_trim_value(fast_trim_value), .slow_trim_value(slow_trim_value),
        .temp_coefficient_out(temp_coefficient_out),
        .temp_step_out(temp_step_out), .temp_comp_enable(temp_comp_enable),
        .clock_enables(clock_enables), .core_stall(core_stall),
        .interrupt_go(interrupt_go), .conversion_start(conversion_start),
        .sleeping(sleeping));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (interrupt_go === 1'b1) go_cnt++;
        if (conversion_start === 1'b1) conv_cnt++;
        if (cycles == 30000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        reg_req <= '{address: a, write_data: d, write_strobe: 1'b1,
                     read_strobe: 1'b0};
        @(posedge clk);
        reg_req.write_strobe <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_req <= '{address: a, write_data: 8'h00, write_strobe: 1'b0,
                     read_strobe: 1'b1};
        @(posedge clk);
        reg_req.read_strobe <= 1'b0;
        @(negedge clk);
        d = read_data;
    endtask : rd

    task automatic check_all();
        logic [7:0] d;
        logic       en;
        en = m[2][7];
        for (int i = 0; i < 5; i++) begin
            rd(`FAST_TRIM_OFFSET + 8'(i), d);
            chk("register read", d, m[i] & RD_MASK[i]);
        end
        rd(8'h10, d);
        chk("unmapped read", d, 0);
        chk("fast trim out", fast_trim_value, m[0]);
        chk("slow trim out", slow_trim_value, m[3] & 8'h03);
        chk("comp enable", temp_comp_enable, en);
        chk("coef out", temp_coefficient_out, en ? m[1] : 8'h00);
        chk("step out", temp_step_out, en ? m[2][6:0] : 7'h00);
    endtask : check_all

    task automatic wait_sleep(logic want);
        for (int i = 0; i < 10 && sleeping !== want; i++) @(posedge clk);
        chk("sleeping", sleeping, want);
    endtask : wait_sleep

    task automatic pulse_sleep();
        @(posedge clk);
        sleep_instruction <= 1'b1;
        @(posedge clk);
        sleep_instruction <= 1'b0;
    endtask : pulse_sleep

    task automatic do_sleep(int md, logic conv);
        int b;
        int n;
        int g0;
        int c0;
        int w;
        m[4] = {1'b0, 2'(md), 1'b1, 4'h0};
        wr(`CORE_CTRL_OFFSET, m[4]);
        converter_enabled <= conv;
        c0 = conv_cnt;
        pulse_sleep();
        wait_sleep(1'b1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("gates in sleep", clock_enables,
            GATES[md]);
        chk("conversion", conv_cnt - c0, conv && md < 2);
        g0 = go_cnt;
        wake_pins <= wake_events_t'(FORBID[md]);
        repeat (20) @(posedge clk);
        chk("no wake", {sleeping, 8'(go_cnt - g0)}, 9'h100);
        wake_pins <= '0;
        repeat (3) @(posedge clk);
        do b = $urandom % 10; while (!ALLOW[md][b]);
        n = 0;
        w = md == 3 ? `STANDBY_WAKE_CYCLES : `OSC_STARTUP_CYCLES;
        // level source holds until the handler is entered
        wake_pins <= wake_events_t'(10'h001 << b);
        while (interrupt_go !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        // two sync flops, one decision cycle and the pulse itself
        chk("wake cycles", n, w + `WAKE_STALL_CYCLES + 4);
        @(posedge clk);
        wake_pins <= '0;
        wait_sleep(1'b0);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("one go pulse", go_cnt - g0, 1);
        chk("gates awake", {clock_enables, core_stall}, 6'h3e);
        m[4] = {1'b0, 2'(md), 5'h00};
        wr(`CORE_CTRL_OFFSET, m[4]);
        check_all();
    endtask : do_sleep

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        m = '{FAST_F, COEF_F, STEP_F, SLOW_F, 8'h00};
    endtask : do_reset

    initial begin
        logic [7:0] v;
        reset_n = 1'b0;
        reg_req = '0;
        sleep_instruction = 1'b0;
        converter_enabled = 1'b0;
        wake_pins = '0;
        void'($urandom(32'h5955));
        do_reset();
        check_all();
        for (int k = 0; k < 6; k++) begin
            // small steps only: large jumps need the core held in reset
            v = 8'($urandom % 8'h21);
            // never wrap: a wrap would be a jump far beyond 0x20
            if (m[0] < 8'hdf && (k % 2 == 0 || m[0] < v))
                m[0] = m[0] + v;
            else
                m[0] = m[0] - v;
            // no memory write is ever pending here, so any trim is safe
            wr(`FAST_TRIM_OFFSET, m[0]);
            m[1] = 8'($urandom);
            wr(`TEMP_COEF_OFFSET, m[1]);
            m[2] = {k[0], 7'($urandom)};
            wr(`TEMP_STEP_OFFSET, m[2]);
            m[3] = 8'($urandom);
            wr(`SLOW_TRIM_OFFSET, m[3]);
            check_all();
        end
        m[4] = {1'b0, 2'(MODE_POWER_DOWN), 5'h00};
        wr(`CORE_CTRL_OFFSET, m[4]);
        pulse_sleep();
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("unarmed sleep", sleeping, 0);
        for (int md = 0; md < 4; md++)
            do_sleep(md, md < 2 ? 1'b1 : 1'($urandom));
        wr(`CORE_CTRL_OFFSET, {1'b0, 2'(MODE_STANDBY), 5'h10});
        pulse_sleep();
        wait_sleep(1'b1);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("reset wakes", {sleeping, clock_enables}, 6'h1f);
        do_reset();
        check_all();
        conclude();
    end
endmodule : osc_trim_and_sleep_control_tb
